// ===== sms_top.sv
/*
  Safety monitor status aggregation: supply, clock, digital and link fault
  flags, indicators and conversion counters, all on plain ports.
  Assumes analog detector levels, supply good levels, oscillator ticks and
  GPIO pins are asynchronous; all other inputs come from CLK logic.
*/
`timescale 1ns/1ns
// Behaviour
// - Frequency mismatch beyond threshold clears frequency flag
// - Slow main clock clears main watchdog flag
// - Slow diagnostic oscillator clears its watchdog flag
// - Main clock internal or external, compared
// - Any supply below POR holds reset
// - Overvoltage stops regulator, except during diagnostic
// - Current limit sets regulator current flags
// - Host threshold selects applied to monitors
// - Three ground pins watched, common ground not
// - Three section CRC monitors, enables, flags
// - Memory CRC and GPIO readback, no enables
// - Link fault flags; timeout, clock count enabled
// - Response, lock, clock, mode, sequencer, bank indicators
// - Two-bit conversion and sequence counters
// - Enabled monitor fault drives flag low
// - Non-link flags held until host clears or disables the monitor
// - Link flags self-clear after clean frame
module sms_top (
  input  wire logic                           CLK,
  input  wire logic                           RST,
  input  wire logic [sms_pkg::SUP_N-1:0]      SUPPLY_DET,
  input  wire logic [sms_pkg::SUP_N-1:0]      SUPPLY_EN,
  input  wire logic [sms_pkg::SUP_N-1:0]      SUPPLY_CLR,
  input  wire logic [sms_pkg::LDO_N-1:0]      OV_DIAG_ACTIVE,
  input  wire logic [sms_pkg::LDO_N-1:0]      POR_OK,
  input  wire logic                           IO_SUPPLY_OV_THRESHOLD_SEL,
  input  wire logic                           IO_SUPPLY_UV_THRESHOLD_SEL,
  input  wire logic [1:0]                     ANALOG_LDO_OVERTEMP_THRESHOLD,
  input  wire logic [1:0]                     IO_LDO_OVERTEMP_THRESHOLD,
  input  wire logic                           OSC_MAIN_TICK,
  input  wire logic                           EXT_CLK_TICK,
  input  wire logic                           DIAG_OSC_TICK,
  input  wire logic                           CLK_SRC_EXT,
  input  wire logic [sms_pkg::CLKF_N-1:0]     CLK_MON_EN,
  input  wire logic [sms_pkg::CLKF_N-1:0]     CLK_CLR,
  input  wire logic [15:0]                    CLK_DEVIATION_THRESHOLD,
  input  wire logic [sms_pkg::DIG_N-1:0]      CRC_MISMATCH,
  input  wire logic [2:0]                     SECTION_CRC_ENABLE,
  input  wire logic [sms_pkg::DIG_N-1:0]      DIG_CLR,
  input  wire logic [1:0]                     MEMORY_CRC_DIAG_FIELD,
  input  wire logic                           OTP_BANK,
  input  wire logic [2:0]                     READBACK_DIAG_ENABLE,
  input  wire logic [sms_pkg::GPIO_N-1:0]     GPIO_PIN,
  input  wire logic                           FRAME_CHECK_ERR,
  input  wire logic                           FRAME_TIMEOUT_ERR,
  input  wire logic                           SERIAL_CLK_COUNT_ERR,
  input  wire logic                           BAD_ADDRESS_ERR,
  input  wire logic                           TIMEOUT_EN,
  input  wire logic                           SCLK_COUNTER_EN,
  input  wire logic                           FRAME_END,
  input  wire logic [3:0]                     CMD_RESPONSE,
  input  wire logic                           LOCK_STATE,
  input  wire logic                           MODE_STATE,
  input  wire logic                           SEQ_RUNNING,
  input  wire logic                           CONV_A_DONE,
  input  wire logic                           CONV_B_DONE,
  input  wire logic                           SEQ_DONE,
  output logic      [sms_pkg::SUP_N-1:0]      SUPPLY_STATUS,
  output logic      [sms_pkg::CLKF_N-1:0]     CLOCK_STATUS,
  output sms_pkg::sms_digital_s               DIGITAL_STATUS,
  output sms_pkg::sms_status_msb_s            STATUS_MSB,
  output sms_pkg::sms_status_lsb_s            STATUS_LSB,
  output sms_pkg::sms_mon_cfg_s               MON_CFG,
  output logic      [sms_pkg::GPIO_N-1:0]     GPI_DATA,
  output logic      [sms_pkg::LDO_N-1:0]      LDO_ON,
  output logic                                CORE_RST
);

  localparam int SYNC_N = sms_pkg::SUP_N + sms_pkg::LDO_N + 3 + sms_pkg::GPIO_N;
  localparam logic [15:0] WIN_LAST = 16'(sms_pkg::WIN_CYC - 1);

  typedef struct packed {
    logic [SYNC_N-1:0]              sync1;
    logic [SYNC_N-1:0]              sync2;
    logic [15:0]                    win_cnt;
    logic                           win_end;
    logic                           eval;
    logic [sms_pkg::FLT_N-1:0]      flt;
    logic [sms_pkg::COMM_N-1:0]     comm;
    logic                           frame_bad;
    sms_pkg::sms_status_msb_s       msb;
    sms_pkg::sms_status_lsb_s       lsb;
    sms_pkg::sms_digital_s          dig;
    sms_pkg::sms_mon_cfg_s          cfg;
    logic [sms_pkg::GPIO_N-1:0]     gpi;
    logic [sms_pkg::LDO_N-1:0]      ldo_on;
    logic                           core_rst;
  } sms_state_s;

  sms_state_s s_r;
  sms_state_s s_nxt;

  logic [SYNC_N-1:0]              raw;
  logic [sms_pkg::SUP_N-1:0]      sup_s;
  logic [sms_pkg::LDO_N-1:0]      por_s;
  logic                           osc_s;
  logic                           ext_s;
  logic                           diag_s;
  logic [sms_pkg::GPIO_N-1:0]     gpio_s;
  logic                           main_tick;
  logic [15:0]                    main_cnt;
  logic [15:0]                    diag_cnt;
  logic [15:0]                    diff;
  logic [sms_pkg::FLT_N-1:0]      det;
  logic [sms_pkg::FLT_N-1:0]      en;
  logic [sms_pkg::FLT_N-1:0]      clr;
  logic [sms_pkg::COMM_N-1:0]     comm_ev;
  logic [sms_pkg::COMM_N-1:0]     comm_en;
  logic                           por_fail;

  assign raw = {GPIO_PIN, DIAG_OSC_TICK, EXT_CLK_TICK, OSC_MAIN_TICK, POR_OK, SUPPLY_DET};
  assign {gpio_s, diag_s, ext_s, osc_s, por_s, sup_s} = s_r.sync2;

  // Selected main clock source is what gets checked
  assign main_tick = CLK_SRC_EXT ? ext_s : osc_s;

  sms_edge_count #(.CNT_W(16)) u_main_cnt (
    .clk     (CLK),
    .rst     (RST),
    .sig     (main_tick),
    .win_end (s_r.win_end),
    .cnt     (main_cnt)
  );

  sms_edge_count #(.CNT_W(16)) u_diag_cnt (
    .clk     (CLK),
    .rst     (RST),
    .sig     (diag_s),
    .win_end (s_r.win_end),
    .cnt     (diag_cnt)
  );

  assign diff = (main_cnt > diag_cnt) ? (main_cnt - diag_cnt) : (diag_cnt - main_cnt);
  assign por_fail = ~&por_s;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.sync1 = raw;
    s_nxt.sync2 = s_r.sync1;

    // Measurement window; counts are valid one cycle after its end
    s_nxt.win_end = (s_r.win_cnt == WIN_LAST);
    s_nxt.win_cnt = s_nxt.win_end ? 16'h0000 : s_r.win_cnt + 16'h0001;
    s_nxt.eval    = s_r.win_end;

    // Supply detectors: OV, UV, oscillation, overtemperature, current limit,
    // and only the three monitored ground pins
    det = '0;
    det[sms_pkg::SUP_LO +: sms_pkg::SUP_N] = sup_s;
    det[sms_pkg::CLKF_LO + sms_pkg::CK_FREQ] =
      s_r.eval & (diff > CLK_DEVIATION_THRESHOLD);
    det[sms_pkg::CLKF_LO + sms_pkg::CK_MAIN_WD] =
      s_r.eval & (main_cnt < sms_pkg::MAIN_WD_MIN_CNT);
    det[sms_pkg::CLKF_LO + sms_pkg::CK_DIAG_WD] =
      s_r.eval & (diag_cnt < sms_pkg::DIAG_WD_MIN_CNT);
    det[sms_pkg::DIG_LO +: sms_pkg::DIG_N] = CRC_MISMATCH;

    // Memory CRC has no enable and always runs
    en  = {1'b1, SECTION_CRC_ENABLE, CLK_MON_EN, SUPPLY_EN};
    clr = {DIG_CLR, CLK_CLR, SUPPLY_CLR};

    // Detection wins over a clear in the same cycle
    for (int i = 0; i < sms_pkg::FLT_N; i++) begin
      if (!en[i]) begin
        s_nxt.flt[i] = 1'b1;
      end else if (det[i]) begin
        s_nxt.flt[i] = 1'b0;
      end else if (clr[i]) begin
        s_nxt.flt[i] = 1'b1;
      end
    end

    // Link monitors: check and address always on, others enabled
    comm_en = {1'b1, SCLK_COUNTER_EN, TIMEOUT_EN, 1'b1};
    comm_ev = {BAD_ADDRESS_ERR, SERIAL_CLK_COUNT_ERR, FRAME_TIMEOUT_ERR, FRAME_CHECK_ERR}
              & comm_en;
    for (int i = 0; i < sms_pkg::COMM_N; i++) begin
      if (!comm_en[i]) begin
        s_nxt.comm[i] = 1'b1;
      end else if (comm_ev[i]) begin
        s_nxt.comm[i] = 1'b0;
      end
    end
    if (FRAME_END) begin
      // Clean frame: flags read high again from frame end until the next link event
      if (!(s_r.frame_bad || (|comm_ev))) begin
        s_nxt.comm = '1;
      end
      s_nxt.frame_bad = 1'b0;
    end else if (|comm_ev) begin
      s_nxt.frame_bad = 1'b1;
    end

    // Regulator protection ignores the enables; diagnostics never trip it
    for (int i = 0; i < sms_pkg::LDO_N; i++) begin
      s_nxt.ldo_on[i] = ~(sup_s[sms_pkg::SUP_OV_LO + i] & ~OV_DIAG_ACTIVE[i]);
    end

    s_nxt.cfg.io_supply_ov_threshold_sel    = IO_SUPPLY_OV_THRESHOLD_SEL;
    s_nxt.cfg.io_supply_uv_threshold_sel    = IO_SUPPLY_UV_THRESHOLD_SEL;
    s_nxt.cfg.analog_ldo_overtemp_threshold = ANALOG_LDO_OVERTEMP_THRESHOLD;
    s_nxt.cfg.io_ldo_overtemp_threshold     = IO_LDO_OVERTEMP_THRESHOLD;
    s_nxt.cfg.memory_crc_diag_field         = MEMORY_CRC_DIAG_FIELD;
    s_nxt.cfg.readback_diag_enable          = READBACK_DIAG_ENABLE;
    s_nxt.gpi                               = gpio_s;

    s_nxt.dig.flags_n            = s_nxt.flt[sms_pkg::DIG_LO +: sms_pkg::DIG_N];
    s_nxt.dig.otp_bank_indicator = OTP_BANK;

    s_nxt.msb.cmd_response   = CMD_RESPONSE;
    s_nxt.msb.lock_state     = LOCK_STATE;
    s_nxt.msb.clock_source   = CLK_SRC_EXT;
    s_nxt.msb.mode_state     = MODE_STATE;
    s_nxt.msb.supply_comb_n  = &s_nxt.flt[sms_pkg::SUP_LO +: sms_pkg::SUP_N];
    s_nxt.msb.clock_comb_n   = &s_nxt.flt[sms_pkg::CLKF_LO +: sms_pkg::CLKF_N];
    s_nxt.msb.digital_comb_n = &s_nxt.flt[sms_pkg::DIG_LO +: sms_pkg::DIG_N];
    s_nxt.msb.frame_check_fault_flag      = s_nxt.comm[sms_pkg::CM_CHECK];
    s_nxt.msb.frame_timeout_flag          = s_nxt.comm[sms_pkg::CM_TIMEOUT];
    s_nxt.msb.serial_clk_count_fault_flag = s_nxt.comm[sms_pkg::CM_SCLK];
    s_nxt.msb.bad_address_fault_flag      = s_nxt.comm[sms_pkg::CM_ACCESS];

    s_nxt.lsb.sequencer_running_flag = SEQ_RUNNING;
    if (CONV_A_DONE) begin
      s_nxt.lsb.current_adc_a_counter = s_r.lsb.current_adc_a_counter + 2'h1;
    end
    if (CONV_B_DONE) begin
      s_nxt.lsb.current_adc_b_counter = s_r.lsb.current_adc_b_counter + 2'h1;
    end
    if (SEQ_DONE) begin
      s_nxt.lsb.mux_adc_sequence_counter = s_r.lsb.mux_adc_sequence_counter + 2'h1;
    end

    // Supply loss: flags, link state, status words and counters forced to reset; sync, window, config, GPIO and LDO control keep running
    s_nxt.core_rst = por_fail;
    if (por_fail) begin
      s_nxt.flt       = '1;
      s_nxt.comm      = '1;
      s_nxt.frame_bad = 1'b0;
      s_nxt.lsb       = '0;
      s_nxt.msb       = '0;
      s_nxt.msb.supply_comb_n  = 1'b1;
      s_nxt.msb.clock_comb_n   = 1'b1;
      s_nxt.msb.digital_comb_n = 1'b1;
      s_nxt.msb.frame_check_fault_flag      = 1'b1;
      s_nxt.msb.frame_timeout_flag          = 1'b1;
      s_nxt.msb.serial_clk_count_fault_flag = 1'b1;
      s_nxt.msb.bad_address_fault_flag      = 1'b1;
      s_nxt.dig.flags_n = '1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s_r          <= '0;
      s_r.flt      <= '1;
      s_r.comm     <= '1;
      s_r.dig.flags_n <= '1;
      s_r.msb.supply_comb_n  <= sms_pkg::FLAG_RST;
      s_r.msb.clock_comb_n   <= sms_pkg::FLAG_RST;
      s_r.msb.digital_comb_n <= sms_pkg::FLAG_RST;
      s_r.msb.frame_check_fault_flag      <= sms_pkg::FLAG_RST;
      s_r.msb.frame_timeout_flag          <= sms_pkg::FLAG_RST;
      s_r.msb.serial_clk_count_fault_flag <= sms_pkg::FLAG_RST;
      s_r.msb.bad_address_fault_flag      <= sms_pkg::FLAG_RST;
      s_r.ldo_on   <= {sms_pkg::LDO_N{sms_pkg::LDO_RST}};
      s_r.core_rst <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign SUPPLY_STATUS  = s_r.flt[sms_pkg::SUP_LO +: sms_pkg::SUP_N];
  assign CLOCK_STATUS   = s_r.flt[sms_pkg::CLKF_LO +: sms_pkg::CLKF_N];
  assign DIGITAL_STATUS = s_r.dig;
  assign STATUS_MSB     = s_r.msb;
  assign STATUS_LSB     = s_r.lsb;
  assign MON_CFG        = s_r.cfg;
  assign GPI_DATA       = s_r.gpi;
  assign LDO_ON         = s_r.ldo_on;
  assign CORE_RST       = s_r.core_rst;

endmodule

// ===== sms_pkg.sv
/*
  Shared constants and carrier types of the safety monitor status block.
  Assumes one 100 MHz system clock; analog detectors deliver raw levels.
*/
package sms_pkg;

  // Timing
  localparam int CLK_MHZ        = 100;
  localparam int WIN_TIME_US    = 10;
  localparam int WIN_CYC        = WIN_TIME_US * CLK_MHZ;
  localparam int CNT_W          = 16;

  // Missing-clock limits, edges per window
  localparam logic [15:0] MAIN_WD_MIN_CNT = 16'h0014;
  localparam logic [15:0] DIAG_WD_MIN_CNT = 16'h0014;

  // Flag vector layout
  localparam int SUP_N   = 16;
  localparam int CLKF_N  = 3;
  localparam int DIG_N   = 4;
  localparam int FLT_N   = SUP_N + CLKF_N + DIG_N;
  localparam int SUP_LO  = 0;
  localparam int CLKF_LO = SUP_LO + SUP_N;
  localparam int DIG_LO  = CLKF_LO + CLKF_N;
  localparam int COMM_N  = 4;
  localparam int LDO_N   = 3;
  localparam int GPIO_N  = 13;

  // Supply flag positions: A, IO, D order inside each group
  localparam int SUP_OV_LO   = 0;
  localparam int SUP_UV_LO   = 3;
  localparam int SUP_OSC_LO  = 6;
  localparam int SUP_OTW_LO  = 9;
  localparam int SUP_CL_LO   = 11;
  localparam int SUP_DISC_LO = 13;

  // Clock flag positions
  localparam int CK_FREQ    = 0;
  localparam int CK_MAIN_WD = 1;
  localparam int CK_DIAG_WD = 2;

  // Digital flag positions
  localparam int DG_MEM_CRC = 3;

  // Communication flag positions
  localparam int CM_CHECK   = 0;
  localparam int CM_TIMEOUT = 1;
  localparam int CM_SCLK    = 2;
  localparam int CM_ACCESS  = 3;

  // Reset values
  localparam logic FLAG_RST = 1'b1;
  localparam logic LDO_RST  = 1'b1;

  typedef struct packed {
    logic [3:0] cmd_response;
    logic       lock_state;
    logic       clock_source;
    logic       mode_state;
    logic       supply_comb_n;
    logic       clock_comb_n;
    logic       digital_comb_n;
    logic       frame_check_fault_flag;
    logic       frame_timeout_flag;
    logic       serial_clk_count_fault_flag;
    logic       bad_address_fault_flag;
  } sms_status_msb_s;

  typedef struct packed {
    logic       sequencer_running_flag;
    logic [1:0] current_adc_a_counter;
    logic [1:0] current_adc_b_counter;
    logic [1:0] mux_adc_sequence_counter;
  } sms_status_lsb_s;

  typedef struct packed {
    logic       otp_bank_indicator;
    logic [3:0] flags_n;
  } sms_digital_s;

  typedef struct packed {
    logic       io_supply_ov_threshold_sel;
    logic       io_supply_uv_threshold_sel;
    logic [1:0] analog_ldo_overtemp_threshold;
    logic [1:0] io_ldo_overtemp_threshold;
    logic [1:0] memory_crc_diag_field;
    logic [2:0] readback_diag_enable;
  } sms_mon_cfg_s;

endpackage

// ===== sms_edge_count.sv
/*
  Counts rising edges of an already synchronised tick over one window.
  Assumes the caller supplies a one-cycle window end pulse.
*/
`timescale 1ns/1ns
module sms_edge_count #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             sig,
  input  wire logic             win_end,
  output logic      [CNT_W-1:0] cnt
);

  typedef struct packed {
    logic             prev;
    logic [CNT_W-1:0] run;
    logic [CNT_W-1:0] cnt;
  } sms_ec_state_s;

  sms_ec_state_s s_r;
  sms_ec_state_s s_nxt;
  logic          edge_seen;

  always_comb begin
    s_nxt     = s_r;
    edge_seen = sig & ~s_r.prev;
    s_nxt.prev = sig;
    if (win_end) begin
      // Edge on the closing cycle still belongs to this window
      s_nxt.cnt = s_r.run + {{(CNT_W-1){1'b0}}, edge_seen};
      s_nxt.run = '0;
    end else if (edge_seen) begin
      s_nxt.run = s_r.run + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cnt = s_r.cnt;

endmodule

// ===== sms_top_monitor.sv
/*
  Checker for the safety monitor status block.
  Bound from the bench; sees only ports of sms_top.
*/
`timescale 1ns/1ns
module sms_top_monitor (
  input wire logic                     CLK,
  input wire logic                     RST,
  input wire logic                     CORE_RST,
  input wire logic [3:0]               CRC_MISMATCH,
  input wire logic [2:0]               SECTION_CRC_ENABLE,
  input wire logic [3:0]               DIG_CLR,
  input wire sms_pkg::sms_digital_s    DIGITAL_STATUS,
  input wire sms_pkg::sms_status_msb_s STATUS_MSB,
  input wire sms_pkg::sms_status_lsb_s STATUS_LSB,
  input wire logic                     FRAME_CHECK_ERR,
  input wire logic                     FRAME_TIMEOUT_ERR,
  input wire logic                     SERIAL_CLK_COUNT_ERR,
  input wire logic                     BAD_ADDRESS_ERR,
  input wire logic                     TIMEOUT_EN,
  input wire logic                     FRAME_END,
  input wire logic                     CONV_A_DONE
);
  logic [3:0] err;
  logic       dirty_r;

  default clocking @(posedge CLK); endclocking
  // Supply loss resets flags like RST does
  default disable iff (RST || CORE_RST);

  assign err = {FRAME_CHECK_ERR, FRAME_TIMEOUT_ERR, SERIAL_CLK_COUNT_ERR, BAD_ADDRESS_ERR};

  // An event in the closing cycle still belongs to the ending frame
  always_ff @(posedge CLK) begin
    if (RST || FRAME_END) begin
      dirty_r <= 1'b0;
    end else if (|err) begin
      dirty_r <= 1'b1;
    end
  end

  AST_SEC_SET: assert property (CRC_MISMATCH[0] && SECTION_CRC_ENABLE[0]
    |=> !DIGITAL_STATUS.flags_n[0]) else $error("section CRC flag not set");
  AST_SEC_OFF: assert property (!SECTION_CRC_ENABLE[1]
    |=> DIGITAL_STATUS.flags_n[1]) else $error("disabled CRC flag low");
  AST_MEM_SET: assert property (CRC_MISMATCH[3]
    |=> !DIGITAL_STATUS.flags_n[3]) else $error("memory CRC flag not set");
  AST_HOLD: assert property (!DIGITAL_STATUS.flags_n[2] && SECTION_CRC_ENABLE[2]
    && !DIG_CLR[2] |=> !DIGITAL_STATUS.flags_n[2]) else $error("flag released early");
  AST_COMB: assert property (STATUS_MSB.digital_comb_n
    == &DIGITAL_STATUS.flags_n) else $error("combined flag mismatch");
  AST_LINK_SET: assert property (FRAME_CHECK_ERR
    |=> !STATUS_MSB.frame_check_fault_flag) else $error("link flag not set");
  AST_TO_OFF: assert property (!TIMEOUT_EN
    |=> STATUS_MSB.frame_timeout_flag) else $error("disabled timeout flag low");
  AST_LINK_CLR: assert property (FRAME_END && !dirty_r && !(|err)
    |=> STATUS_MSB[3:0] == 4'hF) else $error("link flags not restored");
  AST_CNT_A: assert property (CONV_A_DONE |=> STATUS_LSB.current_adc_a_counter
    == $past(STATUS_LSB.current_adc_a_counter) + 2'h1) else $error("counter step");
endmodule

// ===== sms_clk_src_model.sv
/*
  Oscillator sources facing the clock monitors: main, external, diagnostic.
  A stopped source stands low; run comes from the bench.
*/
`timescale 1ns/1ns
module sms_clk_src_model (
  input  wire logic [2:0] run,
  output logic            main_tick,
  output logic            ext_tick,
  output logic            diag_tick
);
  initial begin
    main_tick = 1'b0;
    ext_tick = 1'b0;
    diag_tick = 1'b0;
  end
  // Odd half periods stay unrelated to the system clock
  always #19 main_tick = run[0] ? !main_tick : 1'b0;
  always #23 ext_tick = run[1] ? !ext_tick : 1'b0;
  always #21 diag_tick = run[2] ? !diag_tick : 1'b0;
endmodule

// ===== sms_top_test.sv
/*
  Directed bench for sms_top with the oscillator model.
  Assumes one 100 MHz clock; the checker is bound at the foot.
*/
`timescale 1ns/1ns
module sms_top_test;
  logic [15:0] det = '0, sen = 16'hFFFF, sclr = '0, th = 16'h0040;
  logic [2:0]  ovd = '0, por = 3'h7, cen = 3'h7, cclr = '0, cre = 3'h7, rb = '0, run = 3'h7;
  logic [3:0]  mis = '0, dclr = '0, errs = '0, cmd = '0;
  logic [1:0]  aot = '0, iot = '0, mdg = '0;
  logic [12:0] gpio = '0, gpi;
  logic        clk = 1'b0, rst = 1'b1, ovs = 1'b0, uvs = 1'b0, ext = 1'b0, otp = 1'b0;
  logic        to_en = 1'b1, sc_en = 1'b1, fend = 1'b0, lock = 1'b0, mode = 1'b0, sq = 1'b0;
  logic        ca = 1'b0, cb = 1'b0, cs = 1'b0, mt, et, dt, core_rst;
  logic [15:0] sup_st;
  logic [2:0]  clk_st, ldo;
  sms_pkg::sms_digital_s    dig;
  sms_pkg::sms_status_msb_s msb;
  sms_pkg::sms_status_lsb_s lsb;
  sms_pkg::sms_mon_cfg_s    cfg;
  int n_mismatch = 0, n_tests = 0;

  sms_clk_src_model sms_clk_src_model_inst (.run(run), .main_tick(mt), .ext_tick(et),
    .diag_tick(dt));
  sms_top sms_top_inst (.CLK(clk), .RST(rst), .SUPPLY_DET(det), .SUPPLY_EN(sen),
    .SUPPLY_CLR(sclr), .OV_DIAG_ACTIVE(ovd), .POR_OK(por), .IO_SUPPLY_OV_THRESHOLD_SEL(ovs),
    .IO_SUPPLY_UV_THRESHOLD_SEL(uvs), .ANALOG_LDO_OVERTEMP_THRESHOLD(aot),
    .IO_LDO_OVERTEMP_THRESHOLD(iot), .OSC_MAIN_TICK(mt), .EXT_CLK_TICK(et),
    .DIAG_OSC_TICK(dt), .CLK_SRC_EXT(ext), .CLK_MON_EN(cen), .CLK_CLR(cclr),
    .CLK_DEVIATION_THRESHOLD(th), .CRC_MISMATCH(mis), .SECTION_CRC_ENABLE(cre),
    .DIG_CLR(dclr), .MEMORY_CRC_DIAG_FIELD(mdg), .OTP_BANK(otp), .READBACK_DIAG_ENABLE(rb),
    .GPIO_PIN(gpio), .FRAME_CHECK_ERR(errs[3]), .FRAME_TIMEOUT_ERR(errs[2]),
    .SERIAL_CLK_COUNT_ERR(errs[1]), .BAD_ADDRESS_ERR(errs[0]), .TIMEOUT_EN(to_en),
    .SCLK_COUNTER_EN(sc_en), .FRAME_END(fend), .CMD_RESPONSE(cmd), .LOCK_STATE(lock),
    .MODE_STATE(mode), .SEQ_RUNNING(sq), .CONV_A_DONE(ca), .CONV_B_DONE(cb), .SEQ_DONE(cs),
    .SUPPLY_STATUS(sup_st), .CLOCK_STATUS(clk_st), .DIGITAL_STATUS(dig), .STATUS_MSB(msb),
    .STATUS_LSB(lsb), .MON_CFG(cfg), .GPI_DATA(gpi), .LDO_ON(ldo), .CORE_RST(core_rst));

  initial forever #5 clk = ~clk;

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task report_and_stop;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole sequence needs about 8.7k cycles
  initial begin
    #300000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    cyc(8);
    rst <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk({sup_st, clk_st, ldo, dig.flags_n}, 26'h3FF_FFFF);
    chk(lsb, 7'h00);
    chk(core_rst, 1'b0);
    cyc(2100);
    @(negedge clk);
    chk(clk_st, 3'h7);
    run[2] <= 1'b0;
    cyc(2100);
    @(negedge clk);
    chk(clk_st, 3'h2);
    chk(msb.clock_comb_n, 1'b0);
    cyc(1);
    cen[2] <= 1'b0;
    cyc(2);
    @(negedge clk);
    chk(clk_st[2], 1'b1);
    // External source selected, internal stopped: no fault expected
    cyc(1);
    cen[2] <= 1'b1;
    run <= 3'h6;
    ext <= 1'b1;
    cyc(2100);
    cclr <= 3'h7;
    cyc(1);
    cclr <= 3'h0;
    cyc(2);
    @(negedge clk);
    chk(clk_st, 3'h7);
    chk(msb.clock_source, 1'b1);
    cyc(1);
    run <= 3'h4;
    cyc(2100);
    @(negedge clk);
    chk(clk_st, 3'h4);
    for (int i = 0; i < 16; i++) begin
      cyc(1);
      det[i] <= 1'b1;
      cyc(4);
      sclr[i] <= 1'b1;
      cyc(1);
      sclr[i] <= 1'b0;
      @(negedge clk);
      chk(sup_st, 16'(~(16'h0001 << i)));
      chk(msb.supply_comb_n, 1'b0);
      if (i < 3) chk(ldo[i], 1'b0);
      cyc(1);
      det[i] <= 1'b0;
      cyc(4);
      sclr[i] <= 1'b1;
      cyc(1);
      sclr[i] <= 1'b0;
      cyc(1);
      @(negedge clk);
      chk({sup_st, ldo}, 19'h7_FFFF);
    end
    cyc(1);
    sen[3] <= 1'b0;
    ovd[1] <= 1'b1;
    det <= 16'h000A;
    cyc(6);
    @(negedge clk);
    chk(sup_st, 16'hFFFD);
    chk(ldo, 3'h7);
    cyc(1);
    det <= 16'h0000;
    ovs <= 1'b1;
    aot <= 2'h2;
    iot <= 2'h1;
    mdg <= 2'h3;
    rb <= 3'h5;
    cmd <= 4'h9;
    lock <= 1'b1;
    mode <= 1'b1;
    sq <= 1'b1;
    otp <= 1'b1;
    gpio <= 13'h1A5A;
    cyc(6);
    @(negedge clk);
    chk(cfg, 11'h53D);
    chk(gpi, 13'h1A5A);
    chk({msb.cmd_response, msb.lock_state, msb.mode_state}, 6'h27);
    chk({lsb.sequencer_running_flag, dig.otp_bank_indicator}, 2'h3);
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      mis[i] <= 1'b1;
      cyc(1);
      mis[i] <= 1'b0;
      cyc(1);
      @(negedge clk);
      chk(dig.flags_n, 4'(4'hF ^ (4'h1 << i)));
      cyc(1);
      dclr <= 4'hF;
      cyc(1);
      dclr <= 4'h0;
      cyc(1);
      @(negedge clk);
      chk(dig.flags_n, 4'hF);
    end
    for (int k = 0; k < 4; k++) begin
      cyc(1);
      errs[k] <= 1'b1;
      cyc(1);
      errs[k] <= 1'b0;
      cyc(1);
      errs[k] <= 1'b1;
      fend <= 1'b1;
      cyc(1);
      errs[k] <= 1'b0;
      fend <= 1'b0;
      cyc(1);
      @(negedge clk);
      chk(msb[3:0], 4'(4'hF ^ (4'h1 << k)));
      cyc(1);
      fend <= 1'b1;
      cyc(1);
      fend <= 1'b0;
      cyc(1);
      @(negedge clk);
      chk(msb[3:0], 4'hF);
    end
    cyc(1);
    to_en <= 1'b0;
    sc_en <= 1'b0;
    cre <= 3'h5;
    cyc(1);
    errs <= 4'h6;
    mis[1] <= 1'b1;
    cyc(1);
    errs <= 4'h0;
    mis[1] <= 1'b0;
    cyc(1);
    @(negedge clk);
    chk({msb.frame_timeout_flag, dig.flags_n[1]}, 2'h3);
    chk(msb.serial_clk_count_fault_flag, 1'b1);
    cyc(1);
    to_en <= 1'b1;
    sc_en <= 1'b1;
    cre <= 3'h7;
    for (int j = 0; j < 5; j++) begin
      cyc(1);
      ca <= 1'b1;
      cb <= (j < 3);
      cs <= (j < 2);
      cyc(1);
      {ca, cb, cs} <= 3'h0;
    end
    cyc(1);
    @(negedge clk);
    chk(lsb, 7'h5E);
    cyc(1);
    por <= 3'h5;
    cyc(5);
    @(negedge clk);
    chk({core_rst, lsb.current_adc_a_counter}, 3'h4);
    cyc(1);
    por <= 3'h7;
    cyc(6);
    @(negedge clk);
    chk(core_rst, 1'b0);
    report_and_stop();
  end
endmodule

bind sms_top sms_top_monitor sms_top_monitor_inst (.CLK(CLK), .RST(RST), .CORE_RST(CORE_RST),
  .CRC_MISMATCH(CRC_MISMATCH), .SECTION_CRC_ENABLE(SECTION_CRC_ENABLE), .DIG_CLR(DIG_CLR),
  .DIGITAL_STATUS(DIGITAL_STATUS), .STATUS_MSB(STATUS_MSB), .STATUS_LSB(STATUS_LSB),
  .FRAME_CHECK_ERR(FRAME_CHECK_ERR), .FRAME_TIMEOUT_ERR(FRAME_TIMEOUT_ERR),
  .SERIAL_CLK_COUNT_ERR(SERIAL_CLK_COUNT_ERR), .BAD_ADDRESS_ERR(BAD_ADDRESS_ERR),
  .TIMEOUT_EN(TIMEOUT_EN), .FRAME_END(FRAME_END), .CONV_A_DONE(CONV_A_DONE));
